/* File: hw/qls_consts.vh */
// constants for the quad low-side switch control logic
`ifndef QLS_CONSTS_VH
`define QLS_CONSTS_VH

// serial frame layout
`define FRAME_W      16
`define WR_BIT       15
`define ADDR_HI      14
`define ADDR_LO      12
`define DATA_HI      7
`define BITCNT_W     4
`define BYTE_W       3

// frame addresses
`define A_CTRL       3'h0
`define A_MAP        3'h1
`define A_OLEN       3'h2
`define A_CLR        3'h3
`define A_DIAG       3'h4

// reset values
`define CTRL_RST     4'h0
`define MAP_A_RST    4'h4
`define MAP_B_RST    4'h8
`define OLEN_RST     4'h0

// direct input home channels
`define CH_A         2
`define CH_B         3

// synchroniser bundle: reset levels, chip select idles high
`define SYNC_W       19
`define SYNC_RST     19'h0_0002

// timing
`define CLK_NS       8
`define RESTART_NS   10000
`define RESTART_W    16

`endif

/* File: hw/pin_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter            WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             core_clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level
);

    reg [WIDTH-1:0] s1_ff;   // first stage, read only by s2
    reg [WIDTH-1:0] s2_ff;   // second stage
    reg [WIDTH-1:0] s3_ff;   // third stage
    reg [WIDTH-1:0] lvl_ff;  // accepted level
    integer         k;

    // shift chain; a bit is accepted once stages two and three agree
    always @(posedge core_clk) begin
        if (!rstn) begin
            s1_ff  <= RST_VAL;
            s2_ff  <= RST_VAL;
            s3_ff  <= RST_VAL;
            lvl_ff <= RST_VAL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (s2_ff[k] == s3_ff[k]) begin
                    lvl_ff[k] <= s3_ff[k];
                end
            end
        end
    end

    assign level = lvl_ff;

endmodule // pin_sync

/* File: hw/quad_lowside_switch_control.v */
// control, protection and serial port logic of the quad low-side switch
`timescale 1ns/1ps
`include "qls_consts.vh"
module quad_lowside_switch_control #(
    parameter NCH        = 4,
    parameter RESTART_NS = `RESTART_NS
) (
    input  wire           core_clk,
    input  wire           rstn,
    input  wire           sclk_pin,
    input  wire           chip_select_low,
    input  wire           si_pin,
    output wire           so_out,
    output wire           so_oe,
    input  wire           direct_input_a,
    input  wire           direct_input_b,
    input  wire           idle_pin,
    input  wire           vdd_present,
    input  wire [NCH-1:0] overload_sense,
    input  wire [NCH-1:0] overtemp_sense,
    input  wire [NCH-1:0] osm_sense,
    output wire [NCH-1:0] channel_on,
    output wire [NCH-1:0] open_load_current_source,
    output wire           limp_home
);

    // restart time in cycles, rounded up
    localparam [`RESTART_W-1:0] RESTART_CYC =
        (RESTART_NS + `CLK_NS - 1) / `CLK_NS;

    // synchronised pin levels
    wire [`SYNC_W-1:0] raw_pins;
    wire [`SYNC_W-1:0] pins;
    wire               sclk_f;
    wire               cs_f;
    wire               si_f;
    wire               in_a;
    wire               in_b;
    wire               idle_f;
    wire               vdd_f;
    wire [3:0]         ovl_f;
    wire [3:0]         ot_f;
    wire [3:0]         osm_f;

    assign raw_pins = {osm_sense, overtemp_sense, overload_sense, vdd_present,
                       idle_pin, direct_input_b, direct_input_a, si_pin,
                       chip_select_low, sclk_pin};

    // all outside pins pass the three-stage filter
    pin_sync #(
        .WIDTH   (`SYNC_W),
        .RST_VAL (`SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_in   (raw_pins),
        .level    (pins)
    );

    assign sclk_f = pins[0];
    assign cs_f   = pins[1];
    assign si_f   = pins[2];
    assign in_a   = pins[3];
    assign in_b   = pins[4];
    assign idle_f = pins[5];   // idle pin high means normal mode
    assign vdd_f  = pins[6];
    assign ovl_f  = pins[10:7];
    assign ot_f   = pins[14:11];
    assign osm_f  = pins[18:15];

    // serial port state
    reg                 sclk_q_ff;   // previous clock level
    reg                 cs_q_ff;     // previous chip select level
    reg [`FRAME_W-1:0]  shreg_ff;    // shift register, also chain pass-through
    reg [`BITCNT_W-1:0] bitcnt_ff;   // bits modulo frame length
    reg                 got_ff;      // sixteen bits or more seen this frame
    reg                 so_ff;       // serial output bit
    reg                 so_oe_ff;    // serial output drive enable
    reg [2:0]           rsel_ff;     // register returned in next frame

    // programmable registers
    reg [3:0]           ctrl_ff;     // per-channel control bits
    reg [3:0]           map_a_ff;    // channels driven by input a
    reg [3:0]           map_b_ff;    // channels driven by input b
    reg [3:0]           olen_ff;     // open-load source enables
    reg [3:0]           clr_ff;      // one-cycle fault clear pulses
    reg                 limp_ff;     // limp home indication

    // per-channel status gathered from the generate loop
    wire [3:0]          ot_off;
    wire [3:0]          diag_ovl;

    wire sclk_rise = sclk_f & ~sclk_q_ff;
    wire sclk_fall = ~sclk_f & sclk_q_ff;
    wire active    = ~cs_f & vdd_f;
    wire cs_start  = cs_q_ff & ~cs_f & vdd_f;
    wire cs_end    = ~cs_q_ff & cs_f & vdd_f;
    // whole bytes after one full frame, so 8-bit chain partners fit
    wire frame_ok  = cs_end & got_ff & (bitcnt_ff[`BYTE_W-1:0] == {`BYTE_W{1'b0}});
    wire wr_frame  = frame_ok & shreg_ff[`WR_BIT];
    wire [2:0] fr_addr = shreg_ff[`ADDR_HI:`ADDR_LO];
    wire limp      = ~idle_f;

    // answer word chosen by the last frame: read address, or diagnosis after a write
    reg [`FRAME_W-1:0] resp;
    always @* begin
        case (rsel_ff)
            `A_CTRL: resp = {12'h000, ctrl_ff};
            `A_MAP:  resp = {8'h00, map_b_ff, map_a_ff};
            `A_OLEN: resp = {12'h000, olen_ff};
            // latched diagnosis and live status
            default: resp = {diag_ovl, ot_off, osm_f & ~channel_on,
                             in_b, in_a, limp, vdd_f};
        endcase
    end

    // serial shift engine, sample on rising clock, drive on falling
    always @(posedge core_clk) begin
        if (!rstn) begin
            sclk_q_ff <= 1'b0;
            cs_q_ff   <= 1'b1;
            shreg_ff  <= 16'h0000;
            bitcnt_ff <= 4'h0;
            got_ff    <= 1'b0;
            so_ff     <= 1'b0;
            so_oe_ff  <= 1'b0;
        end else begin
            sclk_q_ff <= sclk_f;
            cs_q_ff   <= cs_f;
            so_oe_ff  <= active;
            if (cs_start) begin
                // load answer, first bit out at once
                shreg_ff  <= resp;
                so_ff     <= resp[`FRAME_W-1];
                bitcnt_ff <= 4'h0;
                got_ff    <= 1'b0;
            end else if (active && sclk_rise) begin
                // bits fall through to the next chained device
                shreg_ff  <= {shreg_ff[`FRAME_W-2:0], si_f};
                bitcnt_ff <= bitcnt_ff + 4'h1;
                got_ff    <= got_ff | (bitcnt_ff == {`BITCNT_W{1'b1}});
            end else if (active && sclk_fall) begin
                so_ff <= shreg_ff[`FRAME_W-1];
            end
        end
    end

    // register writes on a whole-frame chip select release
    always @(posedge core_clk) begin
        if (!rstn || !vdd_f) begin
            // settings lost without digital supply
            ctrl_ff  <= `CTRL_RST;
            map_a_ff <= `MAP_A_RST;
            map_b_ff <= `MAP_B_RST;
            olen_ff  <= `OLEN_RST;
            clr_ff   <= 4'h0;
            rsel_ff  <= `A_DIAG;
        end else begin
            clr_ff <= 4'h0;
            if (frame_ok && !shreg_ff[`WR_BIT]) begin
                rsel_ff <= fr_addr;
            end else if (frame_ok) begin
                rsel_ff <= `A_DIAG;
            end
            if (wr_frame) begin
                case (fr_addr)
                    `A_CTRL: ctrl_ff <= shreg_ff[3:0];
                    `A_MAP: begin
                        map_a_ff <= shreg_ff[3:0];
                        map_b_ff <= shreg_ff[`DATA_HI:4];
                    end
                    `A_OLEN: olen_ff <= shreg_ff[3:0];
                    `A_CLR:  clr_ff  <= shreg_ff[3:0];
                    default: ;
                endcase
            end
        end
    end

    // limp home flag
    always @(posedge core_clk) begin
        if (!rstn) begin
            limp_ff <= 1'b0;
        end else begin
            limp_ff <= limp;
        end
    end

    // per-channel drive and protection
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            reg                   on_ff;     // channel drive
            reg                   ovl_ff;    // overload shutdown latch
            reg                   ot_ff;     // over-temperature latch
            reg                   dovl_ff;   // overload diagnosis flag
            reg                   ol_ff;     // open-load source drive
            reg [`RESTART_W-1:0]  rcnt_ff;   // limp home restart timer
            wire lh_in  = (i == `CH_A) ? in_a :
                          (i == `CH_B) ? in_b : 1'b0;
            wire nm_req = ctrl_ff[i] | (map_a_ff[i] & in_a)
                          | (map_b_ff[i] & in_b);
            wire ovl_ev = ovl_f[i] & on_ff;
            wire rdone  = limp && ovl_ff && lh_in &&
                          (rcnt_ff == RESTART_CYC - 1'b1);

            always @(posedge core_clk) begin
                if (!rstn) begin
                    on_ff   <= 1'b0;
                    ovl_ff  <= 1'b0;
                    ot_ff   <= 1'b0;
                    dovl_ff <= 1'b0;
                    ol_ff   <= 1'b0;
                    rcnt_ff <= 16'h0000;
                end else begin
                    // overload switches off, set beats clear
                    if (ovl_ev) begin
                        ovl_ff <= 1'b1;
                    end else if (clr_ff[i] || rdone) begin
                        ovl_ff <= 1'b0;
                    end
                    // thermal shutdown per channel
                    if (ot_f[i]) begin
                        ot_ff <= 1'b1;
                    end else if (clr_ff[i]) begin
                        ot_ff <= 1'b0;
                    end
                    // diagnosis flag stays until cleared
                    if (ovl_ev) begin
                        dovl_ff <= 1'b1;
                    end else if (clr_ff[i]) begin
                        dovl_ff <= 1'b0;
                    end
                    // restart timer runs in limp home with latch set and input high
                    if (limp && ovl_ff && lh_in && !rdone) begin
                        rcnt_ff <= rcnt_ff + 16'h0001;
                    end else begin
                        rcnt_ff <= 16'h0000;
                    end
                    // latched faults hold the channel off
                    on_ff <= (limp ? lh_in : nm_req) & ~ovl_ff & ~ot_ff
                             & ~ovl_ev & ~ot_f[i];
                    ol_ff <= olen_ff[i] & vdd_f;
                end
            end

            assign channel_on[i]               = on_ff;
            assign open_load_current_source[i] = ol_ff;
            assign ot_off[i]                   = ot_ff;
            assign diag_ovl[i]                 = dovl_ff;
        end
    endgenerate

    assign so_out    = so_ff;
    assign so_oe     = so_oe_ff;
    assign limp_home = limp_ff;

endmodule // quad_lowside_switch_control

/* File: verif/qls_sva.sv */
// port-level assertions for the quad low-side switch control
`timescale 1ns/1ps
module qls_sva #(
    parameter NCH = 4
) (
    input wire           core_clk,
    input wire           rstn,
    input wire           sclk_pin,
    input wire           chip_select_low,
    input wire           si_pin,
    input wire           so_out,
    input wire           so_oe,
    input wire           direct_input_a,
    input wire           direct_input_b,
    input wire           idle_pin,
    input wire           vdd_present,
    input wire [NCH-1:0] overload_sense,
    input wire [NCH-1:0] overtemp_sense,
    input wire [NCH-1:0] osm_sense,
    input wire [NCH-1:0] channel_on,
    input wire [NCH-1:0] open_load_current_source,
    input wire           limp_home
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // serial output released soon after deselect
    a_so_released: assert property (chip_select_low [*8] |-> !so_oe)
        else $error("serial output driven while deselected");
    // serial output driven while selected with supply
    a_so_driven: assert property ((!chip_select_low && vdd_present) [*8] |-> so_oe)
        else $error("serial output idle while selected");
    // no serial activity without digital supply
    a_no_supply: assert property (!vdd_present [*8] |-> !so_oe)
        else $error("serial output driven without supply");
    // idle pin low enters limp home
    a_limp_entry: assert property (!idle_pin [*8] |-> limp_home)
        else $error("limp home not entered");
    // idle pin high leaves limp home
    a_limp_exit: assert property (idle_pin [*8] |-> !limp_home)
        else $error("limp home while idle pin high");
    // only channels two and three may run in limp home
    a_limp_side_off: assert property (limp_home && $past(limp_home, 2) |-> channel_on[1:0] == 2'b00)
        else $error("channel zero or one on in limp home");

    // per-channel protection shuts the channel off
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        a_ovl_off: assert property (overload_sense[i] [*6] ##0 channel_on[i] |-> ##1 !channel_on[i])
            else $error("channel on during overload");
        a_otp_off: assert property (overtemp_sense[i] [*6] |-> !channel_on[i])
            else $error("channel on during over-temperature");
    end
endmodule // qls_sva

bind quad_lowside_switch_control qls_sva #(.NCH(NCH)) u_sva (
    .core_clk                 (core_clk),
    .rstn                     (rstn),
    .sclk_pin                 (sclk_pin),
    .chip_select_low          (chip_select_low),
    .si_pin                   (si_pin),
    .so_out                   (so_out),
    .so_oe                    (so_oe),
    .direct_input_a           (direct_input_a),
    .direct_input_b           (direct_input_b),
    .idle_pin                 (idle_pin),
    .vdd_present              (vdd_present),
    .overload_sense           (overload_sense),
    .overtemp_sense           (overtemp_sense),
    .osm_sense                (osm_sense),
    .channel_on               (channel_on),
    .open_load_current_source (open_load_current_source),
    .limp_home                (limp_home)
);

/* File: verif/spi_host_model.sv */
// spi master model of the host microcontroller
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk,
    output logic chip_select_low,
    output logic si,
    input  wire  so_out,
    input  wire  so_oe
);
    logic last_so = 1'b0;                      // last driven serial output level
    wire  so_wire = so_oe ? so_out : ~last_so; // released line shows no stale value

    // remember the level while the device drives
    always @(so_out or so_oe) if (so_oe) last_so = so_out;

    // clock stands low and select high outside frames
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        si = 1'b0;
    end

    // one frame of n bits, mode 0, msb first, 80 ns clock
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0000_0000;
        chip_select_low = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #40 sclk = 1'b1;
            #39 rx = {rx[30:0], so_wire};
            #1 sclk = 1'b0;
        end
        #40 chip_select_low = 1'b1;
        si = 1'b0;
        #120;
    endtask
endmodule // spi_host_model

/* File: verif/quad_lowside_switch_control_bench.sv */
// self-checking bench for the quad low-side switch control
`timescale 1ns/1ps
`include "qls_consts.vh"
module quad_lowside_switch_control_bench;
    logic        core_clk   = 1'b0;
    logic        rstn       = 1'b0;
    logic        in_a       = 1'b0;
    logic        in_b       = 1'b0;
    logic        idle_pin   = 1'b1;
    logic        vdd        = 1'b1;
    logic [3:0]  ovl        = 4'h0;
    logic [3:0]  otp        = 4'h0;
    logic [3:0]  osm        = 4'h0;
    wire  [3:0]  chan;
    wire  [3:0]  olsrc;
    wire         limp;
    wire         sclk;
    wire         csl;
    wire         si;
    wire         so_out;
    wire         so_oe;
    int          n_mismatch = 0;
    int          compares   = 0;
    logic [31:0] rx;
    logic [15:0] w;

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    quad_lowside_switch_control #(.RESTART_NS(200)) u_dut (
        .core_clk                 (core_clk),
        .rstn                     (rstn),
        .sclk_pin                 (sclk),
        .chip_select_low          (csl),
        .si_pin                   (si),
        .so_out                   (so_out),
        .so_oe                    (so_oe),
        .direct_input_a           (in_a),
        .direct_input_b           (in_b),
        .idle_pin                 (idle_pin),
        .vdd_present              (vdd),
        .overload_sense           (ovl),
        .overtemp_sense           (otp),
        .osm_sense                (osm),
        .channel_on               (chan),
        .open_load_current_source (olsrc),
        .limp_home                (limp)
    );

    spi_host_model u_host (
        .sclk            (sclk),
        .chip_select_low (csl),
        .si              (si),
        .so_out          (so_out),
        .so_oe           (so_oe)
    );

    // compare one value, count and report
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write frame: bit15 set, address, data
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.xfer(16, {16'h0000, 1'b1, a, 4'h0, d}, rx);
    endtask

    // first frame selects diagnosis, second returns it
    task automatic diag(output logic [15:0] d);
        u_host.xfer(16, 32'h0000_4000, rx);
        u_host.xfer(16, 32'h0000_4000, rx);
        d = rx[15:0];
    endtask

    // let filters and registers settle, end just after an edge
    task automatic settle;
        repeat (12) @(posedge core_clk);
        #1;
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #300000;
        n_mismatch++;
        conclude;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b1;
        settle;
        chk("chan", 16'(0), 16'(chan));
        chk("limp", 16'(0), 16'(limp));
        chk("olsrc", 16'(0), 16'(olsrc));
        in_a = 1'b1;
        settle;
        chk("chan", 16'(4'h4), 16'(chan));
        in_b = 1'b1;
        settle;
        chk("chan", 16'(4'hC), 16'(chan));
        wr(`A_CTRL, 8'h01);
        settle;
        chk("chan", 16'(4'hD), 16'(chan));
        wr(`A_MAP, 8'h03);
        settle;
        chk("chan", 16'(4'h3), 16'(chan));
        osm = 4'h2;
        ovl = 4'h2;
        settle;
        ovl = 4'h0;
        settle;
        chk("chan", 16'(4'h1), 16'(chan));
        diag(w);
        chk("diag", 16'h202D, w);
        wr(`A_CLR, 8'h02);
        settle;
        chk("chan", 16'(4'h3), 16'(chan));
        otp = 4'h1;
        settle;
        chk("chan", 16'(4'h2), 16'(chan));
        wr(`A_CLR, 8'h01);
        settle;
        chk("chan", 16'(4'h2), 16'(chan));
        otp = 4'h0;
        diag(w);
        chk("diag", 16'h010D, w);
        wr(`A_CLR, 8'h01);
        settle;
        chk("chan", 16'(4'h3), 16'(chan));
        wr(`A_OLEN, 8'h0A);
        settle;
        chk("olsrc", 16'(4'hA), 16'(olsrc));
        // sixteen plus eight bits: chained with an 8-bit partner
        u_host.xfer(24, 32'h00A5_8008, rx);
        settle;
        chk("chain", 16'(8'hA5), 16'(rx[7:0]));
        chk("chan", 16'(4'hB), 16'(chan));
        // broken byte count is refused
        u_host.xfer(20, 32'h0000_800F, rx);
        settle;
        chk("chan", 16'(4'hB), 16'(chan));
        u_host.xfer(32, 32'h8000_8004, rx);
        settle;
        chk("chain", 16'h8000, rx[15:0]);
        chk("chan", 16'(4'h7), 16'(chan));
        vdd = 1'b0;
        settle;
        wr(`A_CTRL, 8'h01);
        settle;
        chk("chan", 16'(4'hC), 16'(chan));
        chk("olsrc", 16'(0), 16'(olsrc));
        vdd = 1'b1;
        in_b = 1'b0;
        settle;
        wr(`A_CTRL, 8'h03);
        settle;
        chk("chan", 16'(4'h7), 16'(chan));
        idle_pin = 1'b0;
        settle;
        chk("limp", 16'(1), 16'(limp));
        chk("chan", 16'(4'h4), 16'(chan));
        ovl = 4'h4;
        settle;
        chk("chan", 16'(0), 16'(chan));
        ovl = 4'h0;
        repeat (40) @(posedge core_clk);
        #1;
        chk("chan", 16'(4'h4), 16'(chan));
        diag(w);
        chk("diag", 16'h4027, w);
        conclude;
    end
endmodule // quad_lowside_switch_control_bench
